// ===== rtl/fbc_pkg.sv
// Constants, timing counts and state codes for the full-bridge commutator.
// Assumes a single 125 MHz system clock.
package fbc_pkg;

	// ************************************************************
	// Clock and dead interval timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEAD_MIN_NS   = 400;
	localparam int DEAD_MAX_NS   = 4000;
	localparam int DEAD_W        = 9;
	// Least time rounds up, longest time rounds down
	localparam logic [DEAD_W-1:0] DEAD_MIN_CYC =
		DEAD_W'((DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [DEAD_W-1:0] DEAD_MAX_CYC = DEAD_W'(DEAD_MAX_NS / CLK_PERIOD_NS);
	localparam logic [DEAD_W-1:0] DEAD_ZERO    = 9'h000;
	localparam logic [DEAD_W-1:0] DEAD_ONE     = 9'h001;

	// ************************************************************
	// Internal oscillator
	// ************************************************************
	localparam int OSC_W = 16;
	localparam logic [OSC_W-1:0] OSC_ZERO = 16'h0000;
	localparam logic [OSC_W-1:0] OSC_ONE  = 16'h0001;

	// ************************************************************
	// Bridge sequencing
	// ************************************************************
	typedef enum logic [1:0] {
		ST_START   = 2'b00,
		ST_CONDUCT = 2'b01,
		ST_DEAD    = 2'b10
	} fbc_state_e;

	localparam logic PHASE_A = 1'b0;
	localparam logic PHASE_B = 1'b1;

endpackage : fbc_pkg

// ===== rtl/fbc_osc.sv
// Internal timing oscillator: emits one-cycle ticks every period cycles.
// Assumes period is held stable; a period of zero models a grounded timing pin.
`timescale 1ns/1ps

module fbc_osc
	import fbc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Control
	input  wire logic [fbc_pkg::OSC_W-1:0] period,
	input  wire logic                  run,
	// Output
	output logic                       tick
);

	logic [OSC_W-1:0] cnt_q;
	logic [OSC_W-1:0] cnt_d;
	logic             tick_q;
	wire              enabled_w = run && (period != OSC_ZERO);
	wire              wrap_w    = cnt_q >= (period - OSC_ONE);

	// Frozen rather than cleared while stopped, so release resumes the phase
	assign cnt_d = !enabled_w ? cnt_q : (wrap_w ? OSC_ZERO : cnt_q + OSC_ONE);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= OSC_ZERO;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= enabled_w && wrap_w;
		end
	end

	assign tick = tick_q;

	// ************************************************************
	// Checks
	// ************************************************************
	osc_freeze_a: assert property (@(posedge clk) disable iff (!rst_n) // RL7
		!run |=> $stable(cnt_q) && !tick)
		else $error("oscillator ran while stopped");

endmodule : fbc_osc

// ===== rtl/fbc_full_bridge_commutator.sv
// Full-bridge gate sequencer: start-up, diagonal commutation, dead interval,
// hold, shutdown and undervoltage return. Inputs are synchronous to clk.
//
// Function
// RL1: After reset sit in start-up: both high gates off, both low gates on.
// RL2: With supply good alternate state A (left-high, right-low) and B (right-high, left-low).
// RL3: Internal oscillator when external clock low; external clock when timing input zero.
// RL4: Each oscillator tick toggles the bridge, giving half frequency at exact 50% duty.
// RL5: Commutation turns all gates off, waits the dead interval, then turns on the opposite pair.
// RL6: Supply dropping while commutating returns the bridge to start-up.
// RL7: Hold stops the internal oscillator and freezes the current conducting state.
// RL8: Hold arriving in a dead interval completes entry into the next conducting state.
// RL9: Releasing hold resumes oscillation and commutation at once, no restart.
// RL10: The controller drives both hold input and hold reference to hold the bridge.
// RL11: Shutdown high with supply good forces all four gates off while asserted.
// RL12: Supply drop overrides shutdown and puts the low gates on.
// RL13: Supply thresholds arrive as one supply-good level: rise starts, fall stops.
`timescale 1ns/1ps

module fbc_full_bridge_commutator
	import fbc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Supply and oscillator selection
	input  wire logic                   high_voltage_supply,
	input  wire logic                   external_clock_input,
	input  wire logic [fbc_pkg::OSC_W-1:0]  timing_network_input,
	input  wire logic [fbc_pkg::DEAD_W-1:0] dead_interval_control,
	// Control circuit
	input  wire logic                   bridge_hold_input,
	input  wire logic                   hold_reference_input,
	input  wire logic                   shutdown_input,
	// Gate drive
	output logic                        left_high_gate,
	output logic                        right_high_gate,
	output logic                        left_low_gate,
	output logic                        right_low_gate
);

	// ************************************************************
	// Input decode
	// ************************************************************
	fbc_state_e        state_q;
	fbc_state_e        state_d;
	logic              phase_q;
	logic              phase_d;
	logic [DEAD_W-1:0] dead_cnt_q;
	logic [DEAD_W-1:0] dead_cnt_d;
	logic              ext_prev_q;
	logic              int_tick_w;
	logic              lh_q;
	logic              rh_q;
	logic              ll_q;
	logic              rl_q;

	// Supply-good level from the threshold comparator with hysteresis
	wire supply_good_w = high_voltage_supply; // RL13
	// Hold needs both the control current and its reference
	wire hold_w        = bridge_hold_input && hold_reference_input; // RL10
	wire ext_tick_w    = external_clock_input && !ext_prev_q; // RL3
	wire tick_w        = int_tick_w || ext_tick_w; // RL3
	// Shutdown only counts while the supply is good
	wire gate_off_w    = shutdown_input && supply_good_w; // RL12

	// Out-of-range settings are clamped to the supported dead window
	wire [DEAD_W-1:0] dead_len_w =
		(dead_interval_control < DEAD_MIN_CYC) ? DEAD_MIN_CYC :
		(dead_interval_control > DEAD_MAX_CYC) ? DEAD_MAX_CYC : dead_interval_control;
	wire dead_done_w = dead_cnt_q >= (dead_len_w - DEAD_ONE); // RL5

	// ************************************************************
	// Internal oscillator
	// ************************************************************
	fbc_osc u_osc (
		.clk    (clk),
		.rst_n  (rst_n),
		.period (timing_network_input),
		.run    (!hold_w), // RL7
		.tick   (int_tick_w)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	// A tick landing inside a dead interval is dropped; ticks are assumed slower
	// than the dead interval that is set, which the bench keeps (400 or 600 cycles).
	always_comb
	begin
		state_d = state_q;
		phase_d = phase_q;
		if (!supply_good_w)
		begin
			state_d = ST_START; // RL6
			phase_d = PHASE_A;
		end
		else
		begin
			unique case (state_q)
				ST_START:
				begin
					state_d = ST_DEAD; // RL2
					phase_d = PHASE_A;
				end
				ST_CONDUCT:
				begin
					if (tick_w && !hold_w) // RL9
					begin
						state_d = ST_DEAD; // RL5
						phase_d = !phase_q; // RL4
					end
				end
				ST_DEAD:
				begin
					// Hold is ignored here so the transition completes
					if (dead_done_w) // RL8
						state_d = ST_CONDUCT;
				end
				default:
				begin
					state_d = ST_START;
					phase_d = PHASE_A;
				end
			endcase
		end
	end

	assign dead_cnt_d = (state_q == ST_DEAD && state_d == ST_DEAD) ?
		dead_cnt_q + DEAD_ONE : DEAD_ZERO;

	// ************************************************************
	// Gate decode
	// ************************************************************
	wire cond_a_w = state_d == ST_CONDUCT && phase_d == PHASE_A; // RL2
	wire cond_b_w = state_d == ST_CONDUCT && phase_d == PHASE_B; // RL2
	wire start_w  = state_d == ST_START; // RL1
	wire lh_d     = cond_a_w && !gate_off_w; // RL11
	wire rl_d     = (cond_a_w || start_w) && !gate_off_w; // RL11
	wire rh_d     = cond_b_w && !gate_off_w; // RL11
	wire ll_d     = (cond_b_w || start_w) && !gate_off_w; // RL11

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q    <= ST_START; // RL1
			phase_q    <= PHASE_A;
			dead_cnt_q <= DEAD_ZERO;
			ext_prev_q <= 1'b0;
			lh_q       <= 1'b0;
			rh_q       <= 1'b0;
			ll_q       <= 1'b1;
			rl_q       <= 1'b1;
		end
		else
		begin
			state_q    <= state_d;
			phase_q    <= phase_d;
			dead_cnt_q <= dead_cnt_d;
			ext_prev_q <= external_clock_input;
			lh_q       <= lh_d;
			rh_q       <= rh_d;
			ll_q       <= ll_d;
			rl_q       <= rl_d;
		end
	end

	assign left_high_gate  = lh_q;
	assign right_high_gate = rh_q;
	assign left_low_gate   = ll_q;
	assign right_low_gate  = rl_q;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	startup_gates_a: assert property ( // RL6
		!supply_good_w |=> ll_q && rl_q && !lh_q && !rh_q && state_q == ST_START)
		else $error("start-up gates wrong after supply drop");

	low_override_a: assert property ( // RL12
		!supply_good_w && shutdown_input |=> ll_q && rl_q)
		else $error("shutdown overrode supply drop");

	no_shoot_a: assert property ( // RL5
		!(lh_q && ll_q) && !(rh_q && rl_q) && !(lh_q && rh_q))
		else $error("shoot-through gate pattern");

	diag_pair_a: assert property ( // RL2
		(lh_q |-> rl_q && !ll_q && !rh_q) and (rh_q |-> ll_q && !rl_q && !lh_q))
		else $error("conducting pair not diagonal");

	shutdown_off_a: assert property ( // RL11
		shutdown_input && supply_good_w |=> !lh_q && !rh_q && !ll_q && !rl_q)
		else $error("gate on during shutdown");

	// A supply drop may legally cut the dead interval short
	dead_min_a: assert property ( // RL5
		state_q == ST_CONDUCT ##1 state_q == ST_DEAD |->
		((state_q == ST_DEAD) [*8]) or (##[0:7] !supply_good_w))
		else $error("dead interval too short");

	dead_exit_a: assert property ( // RL5
		state_q == ST_DEAD && state_d == ST_CONDUCT |->
		dead_cnt_q + DEAD_ONE >= DEAD_MIN_CYC && dead_cnt_q < DEAD_MAX_CYC)
		else $error("dead interval outside window");

	hold_freeze_a: assert property ( // RL7
		state_q == ST_CONDUCT && hold_w && supply_good_w |=>
		state_q == ST_CONDUCT && $stable(phase_q))
		else $error("bridge moved during hold");

	hold_dead_a: assert property ( // RL8
		state_q == ST_DEAD && hold_w && supply_good_w |->
		##[1:512] state_q == ST_CONDUCT || !supply_good_w)
		else $error("dead interval did not complete under hold");

	commute_a: assert property ( // RL4
		state_q == ST_CONDUCT && tick_w && !hold_w && supply_good_w |=>
		state_q == ST_DEAD && phase_q != $past(phase_q))
		else $error("tick did not commutate");

	full_cycle_c: cover property (
		state_q == ST_CONDUCT && phase_q == PHASE_A ##[1:1000]
		state_q == ST_CONDUCT && phase_q == PHASE_B);
	hold_in_dead_c: cover property (state_q == ST_DEAD && hold_w);
	shutdown_c: cover property (shutdown_input && state_q == ST_CONDUCT);
	undervolt_c: cover property (state_q == ST_CONDUCT ##1 !supply_good_w);

endmodule : fbc_full_bridge_commutator

// ===== sim/fbc_bridge_model.sv
// Bridge and control circuit model: external clock, hold pins, leg short watch.
// Assumes the bench drives its requests at the rising clock edge.
`timescale 1ns/1ps

module fbc_bridge_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bench requests
	input  wire logic       ext_en,
	input  wire logic [9:0] ext_half,
	input  wire logic       hold_req,
	// Gates
	input  wire logic       left_high_gate,
	input  wire logic       right_high_gate,
	input  wire logic       left_low_gate,
	input  wire logic       right_low_gate,
	// Device inputs and leg short flag
	output logic            external_clock_input,
	output logic            bridge_hold_input,
	output logic            hold_reference_input,
	output logic            shoot_seen
);
	int cnt;

	// Holding needs current into the control pin and the reference together
	assign bridge_hold_input    = hold_req;
	assign hold_reference_input = hold_req;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			external_clock_input <= 1'b0;
			cnt                  <= 0;
			shoot_seen           <= 1'b0;
		end
		else
		begin
			// Both switches of one leg on would short the supply
			shoot_seen <= shoot_seen | (left_high_gate & left_low_gate)
				| (right_high_gate & right_low_gate);
			if (!ext_en)
			begin
				external_clock_input <= 1'b0;
				cnt                  <= 0;
			end
			else if (cnt >= int'(ext_half) - 1)
			begin
				external_clock_input <= ~external_clock_input;
				cnt                  <= 0;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule : fbc_bridge_model

// ===== sim/full_bridge_commutator_test.sv
// Self-checking bench: gate patterns are cut into runs and compared with
// run lengths reckoned from the dead interval and oscillator period.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module full_bridge_commutator_test;
	import fbc_pkg::*;
	logic clk, rst_n, supply, ext, hold, href, sd, ext_en, hold_req, shoot;
	logic lh, rh, ll, rl;
	// Read directly, so checks do not race the negedge run monitor
	wire [3:0] gate_w = {lh, rh, ll, rl};
	logic [15:0] tnet, lfsr;
	logic [8:0] dead_ctl;
	logic [9:0] ext_half;
	logic [3:0] pat, prev_pat, q_pat[$];
	int q_len[$], run_len, n_mismatch, tests_run, cycles, d, exp_dead, ch;

	fbc_full_bridge_commutator u_fbc_full_bridge_commutator (.clk(clk), .rst_n(rst_n),
		.high_voltage_supply(supply), .external_clock_input(ext),
		.timing_network_input(tnet), .dead_interval_control(dead_ctl),
		.bridge_hold_input(hold), .hold_reference_input(href), .shutdown_input(sd),
		.left_high_gate(lh), .right_high_gate(rh), .left_low_gate(ll),
		.right_low_gate(rl));
	fbc_bridge_model u_fbc_bridge_model (.clk(clk), .rst_n(rst_n), .ext_en(ext_en),
		.ext_half(ext_half), .hold_req(hold_req), .left_high_gate(lh),
		.right_high_gate(rh), .left_low_gate(ll), .right_low_gate(rl),
		.external_clock_input(ext), .bridge_hold_input(hold),
		.hold_reference_input(href), .shoot_seen(shoot));

	// ************************************************************
	// Clock, watchdog, run monitor
	// ************************************************************
	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	always @(negedge clk)
	begin
		pat = {lh, rh, ll, rl};
		if (!(pat inside {4'h0, 4'h3, 4'h6, 4'h9}))
			`CHK(pat, 4'h0)
		if (pat !== prev_pat)
		begin
			q_pat.push_back(prev_pat);
			q_len.push_back(run_len);
			prev_pat = pat;
			run_len = 1;
		end
		else
			run_len++;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic wait_pat(input logic [3:0] want, input int limit);
		int n;
		n = 0;
		while (gate_w !== want && n < limit)
		begin
			@(negedge clk);
			n++;
		end
		`CHK(gate_w, want)
	endtask : wait_pat

	// Skips the first run, which began before the queue was cleared
	task automatic check_runs(input int exp_off, input int exp_on);
		logic [3:0] last_on;
		last_on = 4'h0;
		`CHK(q_pat.size() > 3, 1'b1)
		for (int i = 1; i < q_pat.size(); i++)
		begin
			if (q_pat[i] === 4'h0)
				`CHK(q_len[i], exp_off)
			else
			begin
				`CHK(q_len[i], exp_on)
				`CHK(q_pat[i] !== last_on, 1'b1)
				last_on = q_pat[i];
			end
		end
	endtask : check_runs

	task automatic settle_and_check(input int exp_off, input int exp_on);
		repeat (1300) @(posedge clk);
		q_pat.delete();
		q_len.delete();
		repeat (4000) @(posedge clk);
		check_runs(exp_off, exp_on);
	endtask : settle_and_check

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		{rst_n, supply, sd, ext_en, hold_req} = 5'h00;
		tnet = 16'h0000;
		dead_ctl = 9'h032;
		ext_half = 10'h12c;
		lfsr = 16'hdf32;
		repeat (11) @(posedge clk);
		@(negedge clk);
		`CHK({lh, rh, ll, rl}, 4'h3)
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		supply <= 1'b1;
		wait_pat(4'h9, 200);
		@(posedge clk);
		ext_en <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			lfsr = lfsr_next(lfsr);
			d = (k == 0) ? 10 : (k == 1) ? 500 : 50 + int'(lfsr) % 150;
			dead_ctl <= 9'(d);
			exp_dead = (d < 50) ? 50 : d;
			settle_and_check(exp_dead, 600 - exp_dead);
		end
		ext_en <= 1'b0;
		tnet <= 16'h0190;
		dead_ctl <= 9'h032;
		settle_and_check(50, 350);
		// Enter hold at the start of an A run, far from the next tick
		wait_pat(4'h0, 1000);
		wait_pat(4'h9, 1000);
		@(posedge clk);
		hold_req <= 1'b1;
		ch = 0;
		repeat (1200) @(negedge clk) ch += int'(gate_w !== 4'h9);
		`CHK(ch, 0)
		@(posedge clk);
		hold_req <= 1'b0;
		wait_pat(4'h0, 410);
		@(posedge clk);
		hold_req <= 1'b1;
		wait_pat(4'h6, 60);
		ch = 0;
		repeat (800) @(negedge clk) ch += int'(gate_w !== 4'h6);
		`CHK(ch, 0)
		@(posedge clk);
		sd <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK(gate_w, 4'h0)
		@(posedge clk);
		hold_req <= 1'b0;
		supply <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK(gate_w, 4'h3)
		@(posedge clk);
		sd <= 1'b0;
		supply <= 1'b1;
		wait_pat(4'h9, 100);
		`CHK(shoot, 1'b0)
		tally_and_finish();
	end
endmodule : full_bridge_commutator_test
